/* File: inc/bic_map.svh */
`ifndef BIC_MAP_SVH
`define BIC_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define BIC_CFG_OFS 4'h0
`define BIC_EVT_OFS 4'h4
`define BIC_LOST_OFS 4'h8
`define BIC_COLL_OFS 4'hC

// ==========================================================
// fixed identifiers and reset values
`define BIC_CFG_RESET 16'h000B
`define BIC_CFG_ID 6'h0B
`define BIC_EVT_ID 6'h0C
`define BIC_LOST_ID 6'h10
`define BIC_COLL_ID 6'h12

// ==========================================================
// field positions and masks
`define BIC_SOFT_BIT 6
`define BIC_EN_MASK 16'hBF80
`define BIC_STARVE_EN_BIT 9

// ==========================================================
// counts
`define BIC_HALF_FROM 10'h1FF
`define BIC_HALF_TO 10'h200
`define BIC_EARLY_RX_BYTES 8'h80

`endif

/* File: inc/bic_pkg.sv */
package bic_pkg;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        BIC_RESP_OKAY = 2'h0,
        BIC_RESP_SLVERR = 2'h2
    } bic_resp_t;

    typedef logic [15:0] bic_word_t;
    typedef logic [9:0] bic_count_t;

endpackage

/* File: rtl/bic_sticky.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// sticky flag bank: set wins over a clear in the same cycle
module bic_sticky #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // control
    input wire logic [W-1:0] set,
    input wire logic clr,
    // state
    output logic [W-1:0] flags
);

    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    always_comb begin
        flags_next = (clr ? '0 : flags_reg) | set;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= '0;
        end else if (clk_en) begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule

`default_nettype wire

/* File: rtl/bic_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bic_map.svh"

module bic_top #(
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // eeprom configuration
    input wire logic eeprom_present,
    input wire logic [15:0] eeprom_cfg,
    // buffer events
    input wire logic dma_frame_done_evt,
    input wire logic tx_accept_ready_evt,
    input wire logic tx_starve_evt,
    input wire logic rx_lost_evt,
    input wire logic rx_frame_start,
    input wire logic rx_byte_strobe,
    input wire logic dest_match_evt,
    input wire logic collision_evt,
    // outputs
    output logic host_irq,
    output logic tx_abandon
);

    // ==========================================================
    // bus slave state
    logic aw_held_reg, aw_held_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [15:0] w_data_reg, w_data_next;
    logic [1:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    bic_pkg::bic_resp_t bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    bic_pkg::bic_word_t rdata_reg, rdata_next;
    bic_pkg::bic_resp_t rresp_reg, rresp_next;
    logic aw_fire, w_fire, ar_fire, wr_go;
    logic [3:0] ar_addr;

    assign s_axi_awready = clk_en & ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = clk_en & ~w_held_reg & ~bvalid_reg;
    assign s_axi_arready = clk_en & ~rvalid_reg;
    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire = s_axi_wvalid & s_axi_wready;
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    assign wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign ar_addr = {s_axi_araddr[3:2], 2'h0};

    // ==========================================================
    // block state
    bic_pkg::bic_word_t en_reg, en_next;
    logic load_pending_reg, load_pending_next;
    bic_pkg::bic_count_t lost_cnt_reg, lost_cnt_next;
    bic_pkg::bic_count_t coll_cnt_reg, coll_cnt_next;
    logic [7:0] early_cnt_reg, early_cnt_next;
    logic early_armed_reg, early_armed_next;
    logic irq_reg, irq_next;
    logic abandon_reg, abandon_next;
    logic [9:0] flags, flag_set, en10;
    logic wr_cfg, soft_req, ev_clr, lost_rd, coll_rd;
    logic lost_half, coll_half, early_evt;
    bic_pkg::bic_word_t cfg_wr_val;

    assign wr_cfg = wr_go & (aw_addr_reg == `BIC_CFG_OFS);
    // request bit is never stored, so it cannot stay active
    assign soft_req = wr_cfg & w_strb_reg[0] & w_data_reg[`BIC_SOFT_BIT];
    assign ev_clr = ar_fire & (ar_addr == `BIC_EVT_OFS);
    assign lost_rd = ar_fire & (ar_addr == `BIC_LOST_OFS);
    assign coll_rd = ar_fire & (ar_addr == `BIC_COLL_OFS);
    // a read clear in the same cycle spoils the 1FFh to 200h step, so no warning then
    assign lost_half = rx_lost_evt & ~lost_rd & (lost_cnt_reg == `BIC_HALF_FROM);
    assign coll_half = collision_evt & ~coll_rd & (coll_cnt_reg == `BIC_HALF_FROM);
    assign early_evt = early_armed_reg & rx_byte_strobe & ~rx_frame_start
        & (early_cnt_reg == (`BIC_EARLY_RX_BYTES - 8'h01));

    // flag index i is event bit i+6; index 8 is the unused bit E
    assign flag_set = {dest_match_evt, 1'b0, lost_half, coll_half, early_evt, rx_lost_evt,
        tx_starve_evt, tx_accept_ready_evt, dma_frame_done_evt, soft_req};
    // soft request has no enable of its own
    assign en10 = {en_reg[15:7], 1'b1};

    bic_sticky #(.W(10)) u_flags (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .set(flag_set),
        .clr(ev_clr),
        .flags(flags)
    );

    // ==========================================================
    // next-state logic
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (aw_fire) begin
            aw_held_next = 1'b1;
            aw_addr_next = {s_axi_awaddr[3:2], 2'h0};
        end
        if (w_fire) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata[15:0];
            w_strb_next = s_axi_wstrb[1:0];
        end
        if (wr_go) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            if (aw_addr_reg == `BIC_CFG_OFS) begin
                bresp_next = bic_pkg::BIC_RESP_OKAY;
            end else if (aw_addr_reg == `BIC_EVT_OFS || aw_addr_reg == `BIC_LOST_OFS
                    || aw_addr_reg == `BIC_COLL_OFS) begin
                bresp_next = bic_pkg::BIC_RESP_OKAY;
            end else begin
                bresp_next = bic_pkg::BIC_RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (ar_fire) begin
            rvalid_next = 1'b1;
            rresp_next = bic_pkg::BIC_RESP_OKAY;
            if (ar_addr == `BIC_CFG_OFS) begin
                rdata_next = en_reg | {10'h000, `BIC_CFG_ID};
            end else if (ar_addr == `BIC_EVT_OFS) begin
                rdata_next = {flags, `BIC_EVT_ID};
            end else if (ar_addr == `BIC_LOST_OFS) begin
                rdata_next = {lost_cnt_reg, `BIC_LOST_ID};
            end else if (ar_addr == `BIC_COLL_OFS) begin
                rdata_next = {coll_cnt_reg, `BIC_COLL_ID};
            end else begin
                rdata_next = 16'h0000;
                rresp_next = bic_pkg::BIC_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_comb begin
        en_next = en_reg;
        load_pending_next = 1'b0;
        if (load_pending_reg && eeprom_present) begin
            en_next = eeprom_cfg & `BIC_EN_MASK;
        end
        cfg_wr_val = en_next;
        if (w_strb_reg[0]) begin
            cfg_wr_val[7:0] = w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
            cfg_wr_val[15:8] = w_data_reg[15:8];
        end
        if (wr_cfg) begin
            en_next = cfg_wr_val & `BIC_EN_MASK;
        end
        lost_cnt_next = (lost_rd ? 10'h000 : lost_cnt_reg) + {9'h000, rx_lost_evt};
        coll_cnt_next = (coll_rd ? 10'h000 : coll_cnt_reg) + {9'h000, collision_evt};
        early_cnt_next = early_cnt_reg;
        early_armed_next = early_armed_reg;
        if (rx_frame_start) begin
            early_cnt_next = {7'h00, rx_byte_strobe};
            early_armed_next = 1'b1;
        end else if (early_armed_reg && rx_byte_strobe) begin
            early_cnt_next = early_cnt_reg + 8'h01;
            early_armed_next = ~early_evt;
        end
        irq_next = |(flags & en10);
        abandon_next = tx_starve_evt;
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= bic_pkg::BIC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            rresp_reg <= bic_pkg::BIC_RESP_OKAY;
            en_reg <= `BIC_CFG_RESET & `BIC_EN_MASK;
            load_pending_reg <= 1'b1;
            lost_cnt_reg <= 10'h000;
            coll_cnt_reg <= 10'h000;
            early_cnt_reg <= 8'h00;
            early_armed_reg <= 1'b0;
            irq_reg <= 1'b0;
            abandon_reg <= 1'b0;
        end else if (clk_en) begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            en_reg <= en_next;
            load_pending_reg <= load_pending_next;
            lost_cnt_reg <= lost_cnt_next;
            coll_cnt_reg <= coll_cnt_next;
            early_cnt_reg <= early_cnt_next;
            early_armed_reg <= early_armed_next;
            irq_reg <= irq_next;
            abandon_reg <= abandon_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = {16'h0000, rdata_reg};
    assign s_axi_rresp = rresp_reg;
    assign host_irq = irq_reg;
    assign tx_abandon = abandon_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_SOFT_IRQ: assert property (
        soft_req && clk_en ##1 clk_en |=> host_irq)
        else $error("soft request did not raise host interrupt");
    AST_SOFT_FLAG: assert property (
        soft_req && clk_en |=> flags[0])
        else $error("soft request did not set bit 6 flag");
    AST_SOFT_ONCE: assert property (
        ev_clr && !soft_req && clk_en |=> !flags[0])
        else $error("soft request stayed active after clear");
    AST_STARVE_IRQ: assert property (
        tx_starve_evt && en_reg[`BIC_STARVE_EN_BIT] && clk_en ##1 clk_en |=> host_irq)
        else $error("starve with enable did not interrupt");
    AST_STARVE_ABANDON: assert property (
        tx_starve_evt && clk_en |=> flags[3] && tx_abandon)
        else $error("starve did not set bit 9 flag and abandon");
    AST_RESET_CFG: assert property (
        load_pending_reg |-> en_reg == 16'h0000)
        else $error("enables not clear after reset");
    AST_EEPROM_LOAD: assert property (
        load_pending_reg && eeprom_present && clk_en && !wr_cfg
        |=> en_reg == ($past(eeprom_cfg) & `BIC_EN_MASK))
        else $error("eeprom config not loaded");
    AST_DMA_FLAG: assert property (
        dma_frame_done_evt && clk_en |=> flags[1])
        else $error("dma frame flag not set");
    AST_EARLY_RX: assert property (
        early_evt && clk_en |-> early_cnt_reg == 8'h7F ##1 flags[5])
        else $error("early receive flag wrong");
    AST_COLL_HALF: assert property (
        coll_half && clk_en |=> flags[6] && coll_cnt_reg == `BIC_HALF_TO)
        else $error("collision half-full step not flagged");
    AST_LOST_HALF: assert property (
        lost_half && clk_en |=> flags[7] && lost_cnt_reg == `BIC_HALF_TO)
        else $error("lost counter half-full step not flagged");
    AST_GATE: assert property (
        clk_en && !(|(flags & en10)) |=> !host_irq)
        else $error("interrupt raised without enabled flag");
    AST_ID_FIXED: assert property (
        (en_reg & ~`BIC_EN_MASK) == 16'h0000)
        else $error("non-enable config bits changed");

    COV_SOFT: cover property (soft_req ##[1:4] host_irq);
    COV_EEPROM: cover property (load_pending_reg && eeprom_present && clk_en);
    COV_EVT_READ: cover property (ev_clr ##1 s_axi_rvalid && s_axi_rready);
    COV_HALF: cover property (coll_half || lost_half);

endmodule

`default_nettype wire

/* File: bench/bic_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// axi4-lite host: each channel is released only at its own handshake edge
module bic_host_model (
    // clock
    input wire logic core_clk,
    // write channels
    output logic [3:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [3:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // handshakes are judged half a cycle early: the readys are combinational
    // and would race the edge itself
    // software rewrites one for every further soft interrupt
    task automatic wr(input logic [3:0] a, input logic [15:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge core_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge core_clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata[15:0];
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: bench/buffer_interrupt_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bic_map.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module buffer_interrupt_config_tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic eeprom_present = 1'b0;
    logic [15:0] eeprom_cfg = '0;
    // 0 dma, 1 tx ready, 2 starve, 3 lost, 4 dest, 5 collision, 6 frame start, 7 byte
    logic [7:0] ev = '0;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, host_irq, tx_abandon;
    int error_cnt = 0;
    int n_tests = 0;
    int ebit[5] = '{7, 8, 9, 10, 15};

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    bic_host_model host (.core_clk(core_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    bic_top DUT (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eeprom_present(eeprom_present),
        .eeprom_cfg(eeprom_cfg), .dma_frame_done_evt(ev[0]), .tx_accept_ready_evt(ev[1]),
        .tx_starve_evt(ev[2]), .rx_lost_evt(ev[3]), .dest_match_evt(ev[4]),
        .collision_evt(ev[5]), .rx_frame_start(ev[6]), .rx_byte_strobe(ev[7]),
        .host_irq(host_irq), .tx_abandon(tx_abandon));

    function automatic logic [15:0] cfg_exp(input logic [15:0] v);
        return (v & `BIC_EN_MASK) | `BIC_CFG_RESET;
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic hold(input logic [7:0] m, input int n);
        @(posedge core_clk);
        ev <= m;
        repeat (n) @(posedge core_clk);
        ev <= '0;
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // watchdog: the sequence needs about 1400 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        int i, en, k;
        logic [15:0] d, v, rst_tab[4];
        logic [1:0] r;
        rst_tab = '{`BIC_CFG_RESET, {10'h000, `BIC_EVT_ID}, {10'h000, `BIC_LOST_ID},
            {10'h000, `BIC_COLL_ID}};
        void'($urandom(36176));
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            host.rd(4'(i * 4), d, r);
            `CHK("reset value", rst_tab[i], d)
        end
        repeat (4) begin
            v = 16'($urandom) & 16'hFFBF;
            host.wr(`BIC_CFG_OFS, v, r);
            `CHK("write resp", bic_pkg::BIC_RESP_OKAY, r)
            host.rd(`BIC_CFG_OFS, d, r);
            `CHK("cfg readback", cfg_exp(v), d)
            `CHK("read resp", bic_pkg::BIC_RESP_OKAY, r)
        end
        // soft request with every enable clear still interrupts
        host.wr(`BIC_CFG_OFS, 16'h0040, r);
        wt(3);
        `CHK("soft irq", 1'b1, host_irq)
        host.rd(`BIC_EVT_OFS, d, r);
        `CHK("soft flag", 16'h004C, d)
        wt(6);
        `CHK("soft once", 1'b0, host_irq)
        host.rd(`BIC_CFG_OFS, d, r);
        `CHK("soft bit reads", `BIC_CFG_RESET, d)
        // a further interrupt needs a further write of one
        host.wr(`BIC_CFG_OFS, 16'h0040, r);
        wt(3);
        `CHK("soft again irq", 1'b1, host_irq)
        host.rd(`BIC_EVT_OFS, d, r);
        `CHK("soft again flag", 16'h004C, d)
        // each event masked, then enabled
        for (i = 0; i < 5; i++) begin
            for (en = 0; en < 2; en++) begin
                host.wr(`BIC_CFG_OFS, 16'(en << ebit[i]), r);
                hold(8'(1 << i), 1);
                #1;
                if (i == 2) `CHK("abandon", 1'b1, tx_abandon)
                wt(3);
                `CHK("event irq", 1'(en), host_irq)
                // the block never retries; the host must start the transmit over
                if (i == 2) `CHK("no retry", 1'b0, tx_abandon)
                host.rd(`BIC_EVT_OFS, d, r);
                `CHK("event flag", 1'b1, d[ebit[i]])
            end
        end
        // early receive: 127 bytes not enough, 128th sets the flag
        host.wr(`BIC_CFG_OFS, 16'h0800, r);
        hold(8'hC0, 1);
        hold(8'h80, 126);
        host.rd(`BIC_EVT_OFS, d, r);
        `CHK("early rx 127", 1'b0, d[11])
        hold(8'h80, 1);
        wt(3);
        `CHK("early rx irq", 1'b1, host_irq)
        host.rd(`BIC_EVT_OFS, d, r);
        `CHK("early rx flag", 1'b1, d[11])
        // half-full warnings: k 0 collisions, k 1 lost frames
        for (k = 0; k < 2; k++) begin
            host.wr(`BIC_CFG_OFS, 16'(1 << (12 + k)), r);
            host.rd(k ? `BIC_LOST_OFS : `BIC_COLL_OFS, d, r);
            host.rd(`BIC_EVT_OFS, d, r);
            hold(k ? 8'h08 : 8'h20, 511);
            wt(3);
            `CHK("half irq at 1FF", 1'b0, host_irq)
            host.rd(`BIC_EVT_OFS, d, r);
            `CHK("half flag at 1FF", 1'b0, d[12 + k])
            hold(k ? 8'h08 : 8'h20, 1);
            wt(3);
            `CHK("half irq at 200", 1'b1, host_irq)
            host.rd(`BIC_EVT_OFS, d, r);
            `CHK("half flag at 200", 1'b1, d[12 + k])
            host.rd(k ? `BIC_LOST_OFS : `BIC_COLL_OFS, d, r);
            `CHK("count", {10'h200, k ? `BIC_LOST_ID : `BIC_COLL_ID}, d)
        end
        // second reset with an eeprom image present
        v = 16'($urandom);
        eeprom_cfg <= v;
        eeprom_present <= 1'b1;
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        host.rd(`BIC_CFG_OFS, d, r);
        `CHK("eeprom load", cfg_exp(v), d)
        give_verdict();
    end
endmodule

`default_nettype wire
